//--- core/csi_output_stat_counters.sv
// output port statistics bank: five counters, wrap interrupt, axi4-lite slave
`timescale 1ns/1ps

`include "csi_output_stat_counters_params.svh"

// Function
// - each counter is 16 bits, seen as high byte 15:8 and low byte 7:0
// - reading port 1 frame high returns upper bits, snapshots low, clears counter
// - reading port 1 errored-frame high returns upper bits, snapshots low, clears
// - reading port 1 line high returns upper bits, snapshots low, clears counter
// - reading port 0 errored-line high returns upper bits, snapshots low, clears
// - low byte is read-only snapshot from last high read; reading it changes nothing
// - counter byte registers read zero after reset
// - reading port 0 line high returns upper bits, snapshots low, clears counter
module csi_output_stat_counters (
    // clock and reset
    input  wire logic                      clk_sys,
    input  wire logic                      resetn,
    // counted events, one-cycle pulses from output-port logic on clk_sys
    input  wire logic                      out0_line_evt,
    input  wire logic                      out0_bad_line_evt,
    input  wire logic                      out1_frame_evt,
    input  wire logic                      out1_bad_frame_evt,
    input  wire logic                      out1_line_evt,
    // axi4-lite write address
    input  wire logic                      s_axi_awvalid,
    output logic                           s_axi_awready,
    input  wire logic [`AXI_ADDR_W-1:0]    s_axi_awaddr,
    input  wire logic [2:0]                s_axi_awprot,
    // axi4-lite write data
    input  wire logic                      s_axi_wvalid,
    output logic                           s_axi_wready,
    input  wire logic [`AXI_DATA_W-1:0]    s_axi_wdata,
    input  wire logic [3:0]                s_axi_wstrb,
    // axi4-lite write response
    output logic                           s_axi_bvalid,
    input  wire logic                      s_axi_bready,
    output csi_output_stat_counters_pkg::axi_resp_type s_axi_bresp,
    // axi4-lite read address
    input  wire logic                      s_axi_arvalid,
    output logic                           s_axi_arready,
    input  wire logic [`AXI_ADDR_W-1:0]    s_axi_araddr,
    input  wire logic [2:0]                s_axi_arprot,
    // axi4-lite read data
    output logic                           s_axi_rvalid,
    input  wire logic                      s_axi_rready,
    output logic [`AXI_DATA_W-1:0]         s_axi_rdata,
    output csi_output_stat_counters_pkg::axi_resp_type s_axi_rresp,
    // interrupt
    output logic                           irq
);

    ////////////////////////////////////////////////////////////////////////////////
    // declarations

    localparam int N   = `NUM_COUNTERS;
    localparam int IDW = `AXI_ADDR_W - `IDX_LSB;

    logic [N-1:0]                                 evt_vec;
    logic [N-1:0]                                 read_high_vec;
    logic [N-1:0]                                 wrap_vec;
    csi_output_stat_counters_pkg::byte_reg_type   cnt_high [N];
    csi_output_stat_counters_pkg::byte_reg_type   cnt_low  [N];

    // write channel state
    csi_output_stat_counters_pkg::wr_state_type   wr_state_r;
    logic                                         aw_held_r;
    logic                                         w_held_r;
    logic [IDW-1:0]                               wr_idx_r;
    logic [`AXI_DATA_W-1:0]                       wdata_r;
    logic                                         wlane0_r;
    logic                                         wr_fire;
    logic                                         wr_hit_status;
    logic                                         wr_hit_mask;
    csi_output_stat_counters_pkg::axi_resp_type   wr_resp_nxt;

    // read channel state
    csi_output_stat_counters_pkg::rd_state_type   rd_state_r;
    logic                                         ar_take;
    logic [IDW-1:0]                               rd_idx;
    logic [`AXI_DATA_W-1:0]                       rd_data_nxt;
    csi_output_stat_counters_pkg::axi_resp_type   rd_resp_nxt;
    logic [N-1:0]                                 rd_clear_nxt;

    // interrupt registers
    logic [N-1:0]                                 wrap_status_r;
    logic [N-1:0]                                 wrap_mask_r;
    logic [N-1:0]                                 status_clear;

    ////////////////////////////////////////////////////////////////////////////////
    // counters

    // slot order matches the register map
    assign evt_vec = {out1_line_evt,
                      out1_bad_frame_evt,
                      out1_frame_evt,
                      out0_bad_line_evt,
                      out0_line_evt};

    // one counter per counted event stream
    for (genvar g = 0; g < N; g++)
    begin : g_cnt
        stat_counter #(
            .WIDTH (`CNT_WIDTH)
        ) u_cnt (
            .clk_sys     (clk_sys),
            .resetn      (resetn),
            .event_pulse (evt_vec[g]),
            .read_high   (read_high_vec[g]),
            .high_byte   (cnt_high[g]),
            .low_snap_r  (cnt_low[g]),
            .wrap_pulse  (wrap_vec[g])
        );
    end

    // side effects of a high read happen at the address handshake
    assign read_high_vec = ar_take ? rd_clear_nxt : '0;

    ////////////////////////////////////////////////////////////////////////////////
    // read decode

    assign rd_idx  = s_axi_araddr[`AXI_ADDR_W-1:`IDX_LSB];
    assign ar_take = s_axi_arvalid && s_axi_arready;

    // data, response and clearing strobe for the addressed register
    always_comb
    begin
        rd_data_nxt  = `RDATA_RESET;
        rd_resp_nxt  = `RESP_OKAY;
        rd_clear_nxt = '0;
        case (rd_idx)
            `IDX_OUT0_LINES_HI:
            begin
                rd_data_nxt[7:0]              = cnt_high[`SLOT_OUT0_LINES];
                rd_clear_nxt[`SLOT_OUT0_LINES] = 1'b1;
            end
            `IDX_OUT0_LINES_LO:
            begin
                rd_data_nxt[7:0] = cnt_low[`SLOT_OUT0_LINES];
            end
            `IDX_OUT0_BAD_LINES_HI:
            begin
                rd_data_nxt[7:0]                  = cnt_high[`SLOT_OUT0_BAD_LINES];
                rd_clear_nxt[`SLOT_OUT0_BAD_LINES] = 1'b1;
            end
            `IDX_OUT0_BAD_LINES_LO:
            begin
                rd_data_nxt[7:0] = cnt_low[`SLOT_OUT0_BAD_LINES];
            end
            `IDX_OUT1_FRAMES_HI:
            begin
                rd_data_nxt[7:0]               = cnt_high[`SLOT_OUT1_FRAMES];
                rd_clear_nxt[`SLOT_OUT1_FRAMES] = 1'b1;
            end
            `IDX_OUT1_FRAMES_LO:
            begin
                rd_data_nxt[7:0] = cnt_low[`SLOT_OUT1_FRAMES];
            end
            `IDX_OUT1_BAD_FRAMES_HI:
            begin
                rd_data_nxt[7:0]                   = cnt_high[`SLOT_OUT1_BAD_FRAMES];
                rd_clear_nxt[`SLOT_OUT1_BAD_FRAMES] = 1'b1;
            end
            `IDX_OUT1_BAD_FRAMES_LO:
            begin
                rd_data_nxt[7:0] = cnt_low[`SLOT_OUT1_BAD_FRAMES];
            end
            `IDX_OUT1_LINES_HI:
            begin
                rd_data_nxt[7:0]              = cnt_high[`SLOT_OUT1_LINES];
                rd_clear_nxt[`SLOT_OUT1_LINES] = 1'b1;
            end
            `IDX_OUT1_LINES_LO:
            begin
                rd_data_nxt[7:0] = cnt_low[`SLOT_OUT1_LINES];
            end
            `IDX_WRAP_STATUS:
            begin
                rd_data_nxt[N-1:0] = wrap_status_r;
            end
            `IDX_WRAP_MASK:
            begin
                rd_data_nxt[N-1:0] = wrap_mask_r;
            end
            default:
            begin
                rd_resp_nxt = `RESP_DECERR;  // hole in the map, no side effect
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // read channel

    // one read in flight; a new address waits until the data is taken
    assign s_axi_arready = (rd_state_r == csi_output_stat_counters_pkg::rd_idle);
    assign s_axi_rvalid  = (rd_state_r == csi_output_stat_counters_pkg::rd_respond);

    // read sequencer and registered answer
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            rd_state_r  <= csi_output_stat_counters_pkg::rd_idle;
            s_axi_rdata <= `RDATA_RESET;
            s_axi_rresp <= `RESP_OKAY;
        end
        else
        begin
            case (rd_state_r)
                csi_output_stat_counters_pkg::rd_idle:
                begin
                    if (ar_take)
                    begin
                        s_axi_rdata <= rd_data_nxt;
                        s_axi_rresp <= rd_resp_nxt;
                        rd_state_r  <= csi_output_stat_counters_pkg::rd_respond;
                    end
                end
                csi_output_stat_counters_pkg::rd_respond:
                begin
                    if (s_axi_rready)
                    begin
                        rd_state_r <= csi_output_stat_counters_pkg::rd_idle;
                    end
                end
                default:
                begin
                    rd_state_r <= csi_output_stat_counters_pkg::rd_idle;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // write channel

    // address and data are caught separately, in either order
    assign s_axi_awready = (wr_state_r == csi_output_stat_counters_pkg::wr_collect) && !aw_held_r;
    assign s_axi_wready  = (wr_state_r == csi_output_stat_counters_pkg::wr_collect) && !w_held_r;
    assign s_axi_bvalid  = (wr_state_r == csi_output_stat_counters_pkg::wr_respond);
    assign wr_fire       = (wr_state_r == csi_output_stat_counters_pkg::wr_collect)
                           && aw_held_r && w_held_r;

    // only the interrupt registers take writes; counter bytes answer an error
    always_comb
    begin
        wr_hit_status = 1'b0;
        wr_hit_mask   = 1'b0;
        wr_resp_nxt   = `RESP_OKAY;
        case (wr_idx_r)
            `IDX_WRAP_STATUS:  wr_hit_status = 1'b1;
            `IDX_WRAP_MASK:    wr_hit_mask   = 1'b1;
            `IDX_OUT0_LINES_HI, `IDX_OUT0_LINES_LO,
            `IDX_OUT0_BAD_LINES_HI, `IDX_OUT0_BAD_LINES_LO,
            `IDX_OUT1_FRAMES_HI, `IDX_OUT1_FRAMES_LO,
            `IDX_OUT1_BAD_FRAMES_HI, `IDX_OUT1_BAD_FRAMES_LO,
            `IDX_OUT1_LINES_HI, `IDX_OUT1_LINES_LO:
                               wr_resp_nxt   = `RESP_SLVERR;  // read-only
            default:           wr_resp_nxt   = `RESP_DECERR;
        endcase
    end

    // write sequencer
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            wr_state_r  <= csi_output_stat_counters_pkg::wr_collect;
            aw_held_r   <= 1'b0;
            w_held_r    <= 1'b0;
            wr_idx_r    <= '0;
            wdata_r     <= `RDATA_RESET;
            wlane0_r    <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
        end
        else
        begin
            case (wr_state_r)
                csi_output_stat_counters_pkg::wr_collect:
                begin
                    if (s_axi_awvalid && s_axi_awready)
                    begin
                        aw_held_r <= 1'b1;
                        wr_idx_r  <= s_axi_awaddr[`AXI_ADDR_W-1:`IDX_LSB];
                    end
                    if (s_axi_wvalid && s_axi_wready)
                    begin
                        w_held_r <= 1'b1;
                        wdata_r  <= s_axi_wdata;
                        wlane0_r <= s_axi_wstrb[0];
                    end
                    if (wr_fire)
                    begin
                        aw_held_r   <= 1'b0;
                        w_held_r    <= 1'b0;
                        s_axi_bresp <= wr_resp_nxt;
                        wr_state_r  <= csi_output_stat_counters_pkg::wr_respond;
                    end
                end
                csi_output_stat_counters_pkg::wr_respond:
                begin
                    if (s_axi_bready)
                    begin
                        wr_state_r <= csi_output_stat_counters_pkg::wr_collect;
                    end
                end
                default:
                begin
                    wr_state_r <= csi_output_stat_counters_pkg::wr_collect;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // wrap interrupt

    // write-one-to-clear, gated by byte lane 0
    assign status_clear = (wr_fire && wr_hit_status && wlane0_r) ? wdata_r[N-1:0] : '0;

    // sticky wrap flags; a wrap in the clearing cycle survives
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            wrap_status_r <= `WRAP_RESET;
        end
        else
        begin
            wrap_status_r <= (wrap_status_r & ~status_clear) | wrap_vec;
        end
    end

    // mask register, one enable bit per counter
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            wrap_mask_r <= `WRAP_RESET;
        end
        else if (wr_fire && wr_hit_mask && wlane0_r)
        begin
            wrap_mask_r <= wdata_r[N-1:0];
        end
    end

    // level interrupt, follows the registered flags
    assign irq = |(wrap_status_r & wrap_mask_r);

endmodule

//--- core/csi_output_stat_counters_params.svh
// register indices, field positions, reset values and bus codes of the output statistics bank
`ifndef CSI_OUTPUT_STAT_COUNTERS_PARAMS_SVH
`define CSI_OUTPUT_STAT_COUNTERS_PARAMS_SVH

// counter geometry
`define CNT_WIDTH            16
`define CNT_HI_LSB           8
`define CNT_LO_MSB           7
`define NUM_COUNTERS         5

// counter slots inside the bank
`define SLOT_OUT0_LINES      0
`define SLOT_OUT0_BAD_LINES  1
`define SLOT_OUT1_FRAMES     2
`define SLOT_OUT1_BAD_FRAMES 3
`define SLOT_OUT1_LINES      4

// register indices; byte address is four times the index
`define IDX_OUT0_LINES_HI      10'h094
`define IDX_OUT0_LINES_LO      10'h095
`define IDX_OUT0_BAD_LINES_HI  10'h096
`define IDX_OUT0_BAD_LINES_LO  10'h097
`define IDX_OUT1_FRAMES_HI     10'h098
`define IDX_OUT1_FRAMES_LO     10'h099
`define IDX_OUT1_BAD_FRAMES_HI 10'h09a
`define IDX_OUT1_BAD_FRAMES_LO 10'h09b
`define IDX_OUT1_LINES_HI      10'h09c
`define IDX_OUT1_LINES_LO      10'h09d
`define IDX_WRAP_STATUS        10'h0c0
`define IDX_WRAP_MASK          10'h0c1

// bus geometry
`define AXI_ADDR_W           12
`define AXI_DATA_W           32
`define IDX_LSB              2

// reset values
`define CNT_RESET            16'h0000
`define SNAP_RESET           8'h00
`define WRAP_RESET           5'h00
`define RDATA_RESET          32'h0000_0000

// response codes
`define RESP_OKAY            2'h0
`define RESP_SLVERR          2'h2
`define RESP_DECERR          2'h3

`endif

//--- core/csi_output_stat_counters_pkg.sv
// types shared by the output statistics bank
package csi_output_stat_counters_pkg;

    typedef logic [1:0] axi_resp_type;
    typedef logic [7:0] byte_reg_type;

    typedef enum logic {wr_collect, wr_respond} wr_state_type;
    typedef enum logic {rd_idle, rd_respond} rd_state_type;

endpackage

//--- core/stat_counter.sv
// one 16-bit event counter with clear-on-read high byte and a low-byte snapshot
`timescale 1ns/1ps

`include "csi_output_stat_counters_params.svh"

module stat_counter #(
    parameter int WIDTH = `CNT_WIDTH
) (
    // clock and reset
    input  wire logic             clk_sys,
    input  wire logic             resetn,
    // event and clearing read
    input  wire logic             event_pulse,
    input  wire logic             read_high,
    // byte views and wrap pulse
    output csi_output_stat_counters_pkg::byte_reg_type high_byte,
    output csi_output_stat_counters_pkg::byte_reg_type low_snap_r,
    output logic                  wrap_pulse
);

    logic [WIDTH-1:0] count_r;
    logic [WIDTH-1:0] count_nxt;

    // high byte always shows the live upper bits
    assign high_byte  = count_r[WIDTH-1:WIDTH-8];
    // a wrap is reported only when the step really goes through zero
    assign wrap_pulse = event_pulse && !read_high && (count_r == {WIDTH{1'b1}});

    // clear on high read, keeping an event of the same cycle
    always_comb
    begin
        count_nxt = count_r;
        if (read_high)
        begin
            count_nxt = event_pulse ? WIDTH'(1) : WIDTH'(0);
        end
        else if (event_pulse)
        begin
            count_nxt = count_r + WIDTH'(1);
        end
    end

    // counter state
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            count_r <= `CNT_RESET;
        end
        else
        begin
            count_r <= count_nxt;
        end
    end

    // low snapshot only moves at a high-byte read
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            low_snap_r <= `SNAP_RESET;
        end
        else if (read_high)
        begin
            low_snap_r <= count_r[`CNT_LO_MSB:0];
        end
    end

endmodule

//--- tb/csi_output_stat_counters_asserts.sv
// concurrent checks on the ports of the output statistics bank
`timescale 1ns/1ps
`include "csi_output_stat_counters_params.svh"
module csi_output_stat_counters_asserts (
    // clock and reset
    input logic                   clk_sys,
    input logic                   resetn,
    // write channels
    input logic                   s_axi_awvalid,
    input logic                   s_axi_awready,
    input logic [`AXI_ADDR_W-1:0] s_axi_awaddr,
    input logic                   s_axi_wvalid,
    input logic                   s_axi_wready,
    input logic                   s_axi_bvalid,
    input logic                   s_axi_bready,
    input logic [1:0]             s_axi_bresp,
    // read channels
    input logic                   s_axi_arvalid,
    input logic                   s_axi_arready,
    input logic [`AXI_ADDR_W-1:0] s_axi_araddr,
    input logic                   s_axi_rvalid,
    input logic                   s_axi_rready,
    input logic [`AXI_DATA_W-1:0] s_axi_rdata,
    input logic [1:0]             s_axi_rresp,
    // interrupt
    input logic                   irq
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    logic [9:0] rd_idx_r, wr_idx_r;
    logic       rd_cnt, rd_map, wr_cnt;
    ////////////////////////////////////////////////////////////////////////////////
    // index of the access in flight, its answer comes later
    always_ff @(posedge clk_sys)
    begin
        if (s_axi_arvalid && s_axi_arready)
            rd_idx_r <= s_axi_araddr[11:2];
        if (s_axi_awvalid && s_axi_awready)
            wr_idx_r <= s_axi_awaddr[11:2];
    end
    // counter byte window and the two wrap registers
    assign rd_cnt = (rd_idx_r >= `IDX_OUT0_LINES_HI) && (rd_idx_r <= `IDX_OUT1_LINES_LO);
    assign rd_map = rd_cnt || (rd_idx_r == `IDX_WRAP_STATUS) || (rd_idx_r == `IDX_WRAP_MASK);
    assign wr_cnt = (wr_idx_r >= `IDX_OUT0_LINES_HI) && (wr_idx_r <= `IDX_OUT1_LINES_LO);
    ////////////////////////////////////////////////////////////////////////////////
    property p_read_answer;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_read_answer: assert property (p_read_answer) else $error("no read answer");
    property p_read_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)
            && $stable(s_axi_rresp);
    endproperty
    a_read_hold: assert property (p_read_hold) else $error("read answer dropped");
    property p_read_refuse;
        s_axi_rvalid |-> !s_axi_arready;
    endproperty
    a_read_refuse: assert property (p_read_refuse) else $error("read taken while busy");
    property p_byte_width;
        s_axi_rvalid && rd_cnt |-> s_axi_rdata[31:8] == 24'h0 && s_axi_rresp == `RESP_OKAY;
    endproperty
    a_byte_width: assert property (p_byte_width) else $error("bad counter read");
    property p_unmapped_read;
        s_axi_rvalid && !rd_map |-> s_axi_rresp == `RESP_DECERR && s_axi_rdata == 32'h0;
    endproperty
    a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read");
    property p_counter_write;
        s_axi_bvalid && wr_cnt |-> s_axi_bresp == `RESP_SLVERR;
    endproperty
    a_counter_write: assert property (p_counter_write) else $error("counter written");
    property p_write_answer;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
    endproperty
    a_write_answer: assert property (p_write_answer) else $error("no write answer");
    property p_write_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_write_hold: assert property (p_write_hold) else $error("write answer dropped");
    // never disabled: reset is the antecedent
    property p_reset_state;
        disable iff (1'b0) !resetn |=> !s_axi_rvalid && !s_axi_bvalid && !irq;
    endproperty
    a_reset_state: assert property (p_reset_state) else $error("bad reset state");
endmodule

bind csi_output_stat_counters csi_output_stat_counters_asserts u_chk (
    .clk_sys, .resetn, .irq, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
    .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp
);

//--- tb/tb.sv
// self-checking bench for the output statistics bank
`timescale 1ns/1ps
`include "csi_output_stat_counters_params.svh"
module tb;
    logic        clk_sys = 1'b0;
    logic        resetn  = 1'b0;
    logic [4:0]  evt     = 5'h00;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic [31:0] s_axi_wdata = 32'h0, hole_d;
    logic [3:0]  s_axi_wstrb = 4'h1;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    logic [31:0] s_axi_rdata;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [15:0] exp_cnt [5] = '{default: 16'h0};
    logic [1:0]  resp;
    int          bad_count  = 0;
    int          n_compared = 0;
    integer      seed       = 8;
    ////////////////////////////////////////////////////////////////////////////////
    always #2.5 clk_sys = ~clk_sys;
    csi_output_stat_counters DUT (
        .clk_sys, .resetn, .out0_line_evt(evt[0]), .out0_bad_line_evt(evt[1]),
        .out1_frame_evt(evt[2]), .out1_bad_frame_evt(evt[3]), .out1_line_evt(evt[4]),
        .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_wvalid,
        .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
        .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_rvalid,
        .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .irq
    );
    ////////////////////////////////////////////////////////////////////////////////
    // compares, each counted
    task automatic check_data(input string what, logic [31:0] e, g);
        n_compared++;
        if (g !== e)
        begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic check_resp(input string what, logic [1:0] e, g);
        check_data(what, {30'h0, e}, {30'h0, g});
    endtask
    function automatic logic [11:0] reg_addr(input logic [9:0] idx);
        return {idx, 2'b00};
    endfunction
    // read; ev pulses events on the very edge that takes the address
    task automatic bus_read(input logic [11:0] a, logic [4:0] ev,
                            output logic [31:0] d, logic [1:0] r);
        @(posedge clk_sys);
        s_axi_arvalid <= 1'b1;
        s_axi_araddr  <= a;
        s_axi_rready  <= 1'b1;
        evt           <= ev;
        do @(posedge clk_sys); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        evt           <= 5'h00;
        do @(posedge clk_sys); while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    // aw and w offered together, each released when taken
    task automatic bus_write(input logic [11:0] a, logic [31:0] d, output logic [1:0] r);
        logic aw_done = 1'b0;
        logic w_done  = 1'b0;
        @(posedge clk_sys);
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_bready  <= 1'b1;
        while (!(aw_done && w_done))
        begin
            @(posedge clk_sys);
            if (!aw_done && s_axi_awready === 1'b1)
            begin
                aw_done = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w_done && s_axi_wready === 1'b1)
            begin
                w_done = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge clk_sys); while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd_chk(input logic [11:0] a, logic [31:0] e, logic [4:0] ev);
        logic [31:0] d;
        logic [1:0]  r;
        bus_read(a, ev, d, r);
        check_data($sformatf("rdata at %h", a), e, d);
        check_resp($sformatf("rresp at %h", a), `RESP_OKAY, r);
    endtask
    // random events, tallied as driven
    task automatic burst(input int n);
        logic [31:0] v;
        repeat (n)
        begin
            @(posedge clk_sys);
            v = $random(seed);
            evt <= v[4:0];
            for (int s = 0; s < 5; s++)
                exp_cnt[s] = exp_cnt[s] + 16'(v[s]);
        end
        @(posedge clk_sys);
        evt <= 5'h00;
    endtask
    // high then low; co makes the slot's event hit the clearing read
    task automatic drain(input int s, logic co);
        logic [11:0] hi;
        logic [7:0]  snap;
        hi   = reg_addr(`IDX_OUT0_LINES_HI + 10'(2 * s));
        snap = exp_cnt[s][7:0];
        rd_chk(hi, {24'h0, exp_cnt[s][15:8]}, 5'(co) << s);
        exp_cnt[s] = {15'h0, co};
        rd_chk(hi + 12'h4, {24'h0, snap}, 5'h00);
        rd_chk(hi + 12'h4, {24'h0, snap}, 5'h00);
        rd_chk(hi, {24'h0, exp_cnt[s][15:8]}, 5'h00);
        rd_chk(hi + 12'h4, {24'h0, exp_cnt[s][7:0]}, 5'h00);
        exp_cnt[s] = 16'h0;
    endtask
    task automatic summarize;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // watchdog above the wrap run plus bursts
    initial
    begin
        #(95000 * 5);
        bad_count++;
        summarize();
    end
    // main sequence
    initial
    begin
        repeat (2) @(posedge clk_sys);
        resetn <= 1'b1;
        for (int i = 0; i < 10; i++)
            rd_chk(reg_addr(`IDX_OUT0_LINES_HI + 10'(i)), 32'h0, 5'h00);
        for (int r = 0; r < 3; r++)
        begin
            burst(200 + ($random(seed) & 511));
            for (int s = 0; s < 5; s++)
                drain(s, r[0]);
        end
        // slot 0 runs its full range and wraps
        @(posedge clk_sys);
        evt <= 5'h01;
        repeat (65536) @(posedge clk_sys);
        evt <= 5'h00;
        drain(0, 1'b0);
        rd_chk(reg_addr(`IDX_WRAP_STATUS), 32'h1, 5'h00);
        check_data("irq masked", 32'h0, {31'h0, irq});
        bus_write(reg_addr(`IDX_WRAP_MASK), 32'h1, resp);
        check_resp("mask bresp", `RESP_OKAY, resp);
        @(posedge clk_sys);
        check_data("irq raised", 32'h1, {31'h0, irq});
        bus_write(reg_addr(`IDX_WRAP_STATUS), 32'h1, resp);
        @(posedge clk_sys);
        check_data("irq cleared", 32'h0, {31'h0, irq});
        rd_chk(reg_addr(`IDX_WRAP_STATUS), 32'h0, 5'h00);
        // refused: counter bytes read-only, holes decode to nothing
        bus_write(reg_addr(`IDX_OUT1_FRAMES_LO), 32'hff, resp);
        check_resp("counter bresp", `RESP_SLVERR, resp);
        rd_chk(reg_addr(`IDX_OUT1_FRAMES_LO), 32'h0, 5'h00);
        bus_write(12'h100, 32'h1, resp);
        check_resp("hole bresp", `RESP_DECERR, resp);
        bus_read(12'h100, 5'h00, hole_d, resp);
        check_data("hole rdata", 32'h0, hole_d);
        check_resp("hole rresp", `RESP_DECERR, resp);
        summarize();
    end
endmodule
